// file: core/mop_pkg.sv
// Constants and types of the motor overload protection block
`default_nettype none
package mop_pkg;
    localparam int CLK_MHZ = 250;
    // Reset values of the configuration
    localparam logic [15:0] NOM_MA_RST   = 16'h0BB8;
    localparam logic [3:0]  OVL_FAC_RST  = 4'h2;
    localparam logic [15:0] TC_S_RST     = 16'h0708;
    localparam logic [7:0]  WARN_PCT_RST = 8'h50;
    localparam logic [9:0]  MOT_WARN_RST = 10'h082;
    // Temperature thresholds in degrees Celsius
    localparam logic signed [9:0] HS_ALARM_C = 10'sh050;
    localparam logic signed [9:0] HS_SHUT_C  = 10'sh055;
    localparam logic signed [9:0] MOT_MAX_C  = 10'sh096;
    // Linear sensor conversion: deg = raw * gain / 256 - offset
    localparam logic [7:0] LIN_A_GAIN = 8'h20;
    localparam logic [9:0] LIN_A_OFF  = 10'h064;
    localparam logic [7:0] LIN_B_GAIN = 8'h1C;
    localparam logic [9:0] LIN_B_OFF  = 10'h050;
    // Model step is one current sample; gain k = 2^40 * dt / T
    localparam longint CUR_DT_NS = 62500;
    localparam longint KNUM      = ((64'h1 << 40) * CUR_DT_NS) / 1000000000;
    localparam longint OVL_TC_S  = 1800;
    localparam logic [23:0] K_RST = 24'(KNUM / TC_S_RST);
    localparam logic [23:0] K_OVL = 24'(KNUM / OVL_TC_S);
    // Trip level is 1.15^2 of nominal squared, scaled by 0.95 so a load at 1.0x the trip current still trips
    localparam longint TRIP_PCT     = 115;
    localparam longint TRIP_LVL_PCT = 95;
    localparam logic [16:0] TRIP_Q16 = 17'((TRIP_PCT * TRIP_PCT * TRIP_LVL_PCT * 65536) / 1000000);
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_I2T  = 8'h1E;
    localparam logic [7:0] ERR_OVL  = 8'h1F;
    // Setpoint output period
    localparam longint SP_PERIOD_NS = 2000000;
    localparam int     SP_CYC       = int'(SP_PERIOD_NS * CLK_MHZ / 1000);
    localparam int     SP_CNT_W     = 19;
    // Position sensing resolutions
    localparam int RES_ANG_W = 12;
    localparam int SC_POS_W  = 15;
    localparam int SC_VEL_W  = 20;
    // Divider
    localparam int         DIV_NW    = 40;
    localparam int         DIV_DW    = 32;
    localparam logic [5:0] DIV_STEPS = 6'h28;
    // Sine-squared ramp weights, mean 64
    localparam logic [7:0] SIN2_W [8] = '{8'h05, 8'h28, 8'h58, 8'h7B, 8'h7B, 8'h58, 8'h28, 8'h05};
    localparam int         SIN2_SH    = 6;
    typedef enum logic [1:0] {SENS_SWITCH = 2'b00, SENS_LIN_A = 2'b01, SENS_LIN_B = 2'b10, SENS_PTC = 2'b11} mop_sens_t;
    typedef enum logic [1:0] {JOB_IDLE = 2'b00, JOB_K = 2'b01, JOB_PCT = 2'b10} mop_job_t;
    typedef enum logic {DV_IDLE = 1'b0, DV_RUN = 1'b1} mop_dv_t;
endpackage : mop_pkg
`default_nettype wire

// file: core/mop_div_if.sv
// Request and answer signals of the model divider
`timescale 1ns/1ns
`default_nettype none
interface mop_div_if import mop_pkg::*; ();
    logic              start;
    logic [DIV_NW-1:0] num;
    logic [DIV_DW-1:0] den;
    logic              busy;
    logic              done;
    logic [DIV_NW-1:0] quo;
    modport master (output start, num, den, input busy, done, quo);
    modport slave  (input start, num, den, output busy, done, quo);
endinterface : mop_div_if
`default_nettype wire

// file: core/mop_div.sv
// Serial restoring divider used for model gain and percentage
`timescale 1ns/1ns
`default_nettype none
module mop_div
    import mop_pkg::*;
(
    input wire logic  core_clk,
    input wire logic  rstn,
    mop_div_if.slave  dv
);
    typedef struct packed {
        mop_dv_t           st;
        logic [5:0]        cnt;
        logic [DIV_DW:0]   rem;
        logic [DIV_NW-1:0] q;
        logic [DIV_DW-1:0] den;
        logic              done;
    } mop_div_st_t;

    mop_div_st_t     st_r;
    mop_div_st_t     st_nxt;
    logic [DIV_DW:0] r2;

    assign r2 = {st_r.rem[DIV_DW-1:0], st_r.q[DIV_NW-1]};

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        case (st_r.st)
            DV_IDLE: begin
                if (dv.start) begin
                    st_nxt.st = DV_RUN;
                    st_nxt.cnt = DIV_STEPS;
                    st_nxt.rem = '0;
                    st_nxt.q = dv.num;
                    st_nxt.den = dv.den;
                end
            end
            DV_RUN: begin
                if (r2 >= {1'b0, st_r.den}) begin
                    st_nxt.rem = r2 - {1'b0, st_r.den};
                    st_nxt.q = {st_r.q[DIV_NW-2:0], 1'b1};
                end else begin
                    st_nxt.rem = r2;
                    st_nxt.q = {st_r.q[DIV_NW-2:0], 1'b0};
                end
                st_nxt.cnt = st_r.cnt - 6'h01;
                if (st_r.cnt == 6'h01) begin
                    st_nxt.st = DV_IDLE;
                    st_nxt.done = 1'b1;
                end
            end
            default: st_nxt.st = DV_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dv.busy = (st_r.st == DV_RUN);
    assign dv.done = st_r.done;
    assign dv.quo  = st_r.q;
endmodule : mop_div
`default_nettype wire

// file: core/mop_top.sv
// Motor overload protection and supervision for one drive axis
// How it works
// R1 - Heat-sink at or above 85 C latches the overtemperature shutdown.
// R2 - Heat-sink at or above 80 C raises a separate alarm flag.
// R3 - Switch and PTC sensors: sensor pin hot gives motor temperature error.
// R4 - Linear sensors: convert to Celsius, settable warning, plus maximum error.
// R5 - Model filters squared current ratio with first-order rise, motor time constant.
// R6 - Model runs only when enabled; warning level settable; error 30 at 100 %.
// R7 - Reset defaults: nominal 3 A, overload factor 2, time constant 1800 s.
// R8 - Model accumulator is zero after reset.
// R9 - Model percentage is readable as an output value.
// R10 - Fixed trip current is 1.15 times the nominal current.
// R11 - Average current equal to trip current trips after finite time.
// R12 - Twice the trip current trips after no less than 8 minutes.
// R13 - Six times the trip current trips after no less than 20 seconds.
// R14 - Fixed trip reports error 31; only nominal current configures it.
// R15 - Fixed trip is always active and has no disable.
// R16 - Setpoint ramps: sine-squared or linear, chosen apart for accel and decel.
// R17 - New setpoint issued every 2 ms.
// R18 - Resolver angle delivered with 12 bits per revolution.
// R19 - Sine-cosine position 15 bits, velocity 20 bits per encoder period.
// R20 - Model is a fixed-point low-pass of squared current, one step per sample.
`timescale 1ns/1ns
`default_nettype none
module mop_top
    import mop_pkg::*;
#(
    parameter int SP_CYCLES = SP_CYC
) (
    input  wire logic               core_clk,
    input  wire logic               rstn,
    input  wire logic               cfg_wr,
    input  wire logic [15:0]        cfg_nom_ma,
    input  wire logic [3:0]         cfg_ovl_fac,
    input  wire logic [15:0]        cfg_tc_s,
    input  wire logic               cfg_i2t_en,
    input  wire logic [7:0]         cfg_warn_pct,
    input  wire logic [1:0]         cfg_sens_type,
    input  wire logic [9:0]         cfg_mot_warn_c,
    input  wire logic               cfg_acc_sin2,
    input  wire logic               cfg_dec_sin2,
    input  wire logic               err_clr,
    input  wire logic               cur_vld,
    input  wire logic [15:0]        cur_ma,
    input  wire logic               hs_vld,
    input  wire logic signed [9:0]  hs_temp,
    input  wire logic               mot_hot,
    input  wire logic               mot_vld,
    input  wire logic [11:0]        mot_raw,
    input  wire logic               sp_run,
    input  wire logic signed [19:0] sp_vel_tgt,
    input  wire logic [15:0]        sp_acc,
    input  wire logic               res_vld,
    input  wire logic [15:0]        res_raw,
    input  wire logic               sc_vld,
    input  wire logic [15:0]        sc_pos_raw,
    input  wire logic [23:0]        sc_vel_raw,
    output logic [15:0]             i2t_pct,
    output logic                    i2t_warn,
    output logic                    i2t_err,
    output logic                    ovl_err,
    output logic [7:0]              err_code,
    output logic                    hs_alarm,
    output logic                    hs_shut,
    output logic signed [9:0]       mot_deg,
    output logic                    mot_warn,
    output logic                    mot_err,
    output logic                    drive_off,
    output logic                    sp_tick,
    output logic signed [31:0]      sp_pos,
    output logic signed [19:0]      sp_vel,
    output logic [RES_ANG_W-1:0]    res_ang,
    output logic [SC_POS_W-1:0]     sc_pos,
    output logic [SC_VEL_W-1:0]     sc_vel
);
    typedef struct packed {
        logic [15:0]          nom;
        logic [3:0]           fac;
        logic [15:0]          tc;
        logic                 en;
        logic [7:0]           wpct;
        mop_sens_t            stype;
        logic [9:0]           mwarn;
        logic                 asin;
        logic                 dsin;
        logic                 cfg_seen;
        logic [55:0]          acc_i2t;
        logic [55:0]          acc_ovl;
        logic [31:0]          k;
        logic                 k_pend;
        mop_job_t             job;
        logic                 dv_start;
        logic [15:0]          pct;
        logic                 i2t_warn;
        logic                 err30;
        logic                 err31;
        logic                 hs_alarm;
        logic                 hs_shut;
        logic [2:0]           hot_sy;
        logic                 hot_s;
        logic signed [9:0]    mdeg;
        logic                 mwarn_f;
        logic                 merr;
        logic                 drv_off;
        logic [7:0]           ecode;
        logic [SP_CNT_W-1:0]  tcnt;
        logic                 tick;
        logic signed [31:0]   pos;
        logic signed [19:0]   vel;
        logic [2:0]           seg;
        logic [RES_ANG_W-1:0] ang;
        logic [SC_POS_W-1:0]  scp;
        logic [SC_VEL_W-1:0]  scv;
    } mop_st_t;
    mop_st_t            st_r;
    mop_st_t            st_nxt;
    mop_div_if          dv ();
    logic [31:0]        nom2;
    logic [19:0]        ilim;
    logic [15:0]        cur_c;
    logic [31:0]        i2_c;
    logic [31:0]        i2_raw;
    logic [31:0]        a30;
    logic [31:0]        aul;
    logic               hit30;
    logic               hitw;
    logic [48:0]        trip_p;
    logic               hit31;
    logic               lin;
    logic signed [9:0]  deg_c;
    logic signed [20:0] sp_diff;
    logic signed [20:0] sp_a;
    logic [23:0]        sp_aw;
    logic               sp_up;
    logic               sp_wrap;
    ////////////////////////////////////////////////////////////////////////
    // One low-pass step: acc += (i2 - acc) * k / 2^40, acc carries 24 fraction bits
    function automatic logic [55:0] lpf(input logic [55:0] a, input logic [31:0] i2, input logic [31:0] k);
        logic signed [56:0] d;
        logic signed [89:0] p;
        d = $signed({1'b0, i2, 24'h000000}) - $signed({1'b0, a});
        p = d * $signed({1'b0, k});
        lpf = a + 56'(p >>> 40);
    endfunction : lpf
    function automatic logic signed [9:0] lin_deg(input mop_sens_t t, input logic [11:0] raw);
        logic [19:0]        p;
        logic signed [12:0] d;
        p = {8'h00, raw} * {12'h000, (t == SENS_LIN_A) ? LIN_A_GAIN : LIN_B_GAIN};
        d = $signed({1'b0, p[19:8]}) - $signed({3'h0, (t == SENS_LIN_A) ? LIN_A_OFF : LIN_B_OFF});
        lin_deg = d[9:0];
    endfunction : lin_deg
    ////////////////////////////////////////////////////////////////////////
    // Model arithmetic
    assign nom2   = {16'h0000, st_r.nom} * {16'h0000, st_r.nom};
    assign ilim   = {4'h0, st_r.nom} * {16'h0000, st_r.fac};
    assign cur_c  = ({4'h0, cur_ma} > ilim) ? ilim[15:0] : cur_ma;
    assign i2_c   = {16'h0000, cur_c} * {16'h0000, cur_c};
    assign i2_raw = {16'h0000, cur_ma} * {16'h0000, cur_ma};
    assign a30    = st_r.acc_i2t[55:24];
    assign aul    = st_r.acc_ovl[55:24];
    assign hit30  = (a30 >= nom2);
    assign hitw   = ({8'h00, a30} * 40'h64) >= ({8'h00, nom2} * {32'h0, st_r.wpct});
    assign trip_p = {17'h0, nom2} * {32'h0, TRIP_Q16}; // [R10]
    assign hit31  = ({1'b0, aul, 16'h0000} >= trip_p);
    assign lin    = (st_r.stype == SENS_LIN_A) || (st_r.stype == SENS_LIN_B);
    assign deg_c  = lin_deg(st_r.stype, mot_raw);
    // Setpoint ramp step
    assign sp_wrap = (st_r.tcnt == SP_CNT_W'(SP_CYCLES - 1));
    assign sp_diff = {sp_vel_tgt[19], sp_vel_tgt} - {st_r.vel[19], st_r.vel};
    assign sp_up   = ((sp_vel_tgt > st_r.vel) && (st_r.vel >= 0)) || ((sp_vel_tgt < st_r.vel) && (st_r.vel <= 0));
    assign sp_aw   = {8'h00, sp_acc} * {16'h0000, SIN2_W[st_r.seg]};
    assign sp_a    = ((sp_up ? st_r.asin : st_r.dsin) ? {3'b000, 18'(sp_aw >> SIN2_SH)} : {5'h00, sp_acc}); // [R16]
    // Divider requests
    assign dv.start = st_r.dv_start;
    assign dv.num   = (st_r.job == JOB_K) ? DIV_NW'(KNUM) : {8'h00, a30} * 40'h64;
    assign dv.den   = (st_r.job == JOB_K) ? {16'h0000, st_r.tc} : nom2;
    mop_div u_div (
        .core_clk (core_clk),
        .rstn     (rstn),
        .dv       (dv.slave)
    );
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        st_nxt.dv_start = 1'b0;
        // Divider jobs: gain after a configuration, else the percentage
        case (st_r.job)
            JOB_IDLE: begin
                if (st_r.k_pend && !dv.busy) begin
                    st_nxt.k_pend = 1'b0;
                    st_nxt.job = JOB_K;
                    st_nxt.dv_start = 1'b1;
                end else if (st_r.en && !dv.busy) begin
                    st_nxt.job = JOB_PCT;
                    st_nxt.dv_start = 1'b1;
                end
            end
            JOB_K: begin
                if (dv.done) begin
                    st_nxt.k = (dv.quo > 40'hFFFFFFFF) ? 32'hFFFFFFFF : dv.quo[31:0];
                    st_nxt.job = JOB_IDLE;
                end
            end
            JOB_PCT: begin
                if (dv.done) begin
                    st_nxt.pct = (dv.quo > 40'hFFFF) ? 16'hFFFF : dv.quo[15:0]; // [R9]
                    st_nxt.job = JOB_IDLE;
                end
            end
            default: st_nxt.job = JOB_IDLE;
        endcase
        // Configuration; zero nominal current, overload factor and time constant are raised to one
        if (cfg_wr) begin
            st_nxt.nom = (cfg_nom_ma == 16'h0000) ? 16'h0001 : cfg_nom_ma; // [R14]
            st_nxt.fac = (cfg_ovl_fac == 4'h0) ? 4'h1 : cfg_ovl_fac;
            st_nxt.tc = (cfg_tc_s == 16'h0000) ? 16'h0001 : cfg_tc_s;
            st_nxt.en = cfg_i2t_en;
            st_nxt.wpct = cfg_warn_pct;
            st_nxt.stype = mop_sens_t'(cfg_sens_type);
            st_nxt.mwarn = cfg_mot_warn_c;
            st_nxt.asin = cfg_acc_sin2;
            st_nxt.dsin = cfg_dec_sin2;
            st_nxt.cfg_seen = 1'b1;
            st_nxt.k_pend = 1'b1;
        end
        // Squared-current model
        if (!st_r.en) begin
            st_nxt.acc_i2t = '0; // [R6] [R8]
            st_nxt.pct = 16'h0000;
            st_nxt.i2t_warn = 1'b0;
        end else begin
            if (cur_vld) begin
                st_nxt.acc_i2t = lpf(st_r.acc_i2t, i2_c, st_r.k); // [R5] [R20]
            end
            st_nxt.i2t_warn = hitw; // [R6]
        end
        st_nxt.err30 = (st_r.err30 & ~err_clr) | (st_r.en & hit30); // [R6]
        // Fixed overload trip, always running, fixed time constant
        if (cur_vld) begin
            st_nxt.acc_ovl = lpf(st_r.acc_ovl, i2_raw, {8'h00, K_OVL}); // [R11] [R12] [R13] [R15]
        end
        st_nxt.err31 = (st_r.err31 & ~err_clr) | hit31; // [R14]
        // Heat sink
        if (hs_vld) begin
            st_nxt.hs_alarm = (hs_temp >= HS_ALARM_C); // [R2]
        end
        st_nxt.hs_shut = (st_r.hs_shut & ~err_clr) | (hs_vld & (hs_temp >= HS_SHUT_C)); // [R1]
        // Motor sensor; pin passes three stages, change taken when the last two agree
        st_nxt.hot_sy = {st_r.hot_sy[1:0], mot_hot};
        if (st_r.hot_sy[1] == st_r.hot_sy[2]) begin
            st_nxt.hot_s = st_r.hot_sy[2];
        end
        if (lin) begin
            if (mot_vld) begin
                st_nxt.mdeg = deg_c; // [R4]
                st_nxt.mwarn_f = (deg_c >= $signed(st_r.mwarn));
            end
            st_nxt.merr = (st_r.merr & ~err_clr) | (mot_vld & (deg_c >= MOT_MAX_C)); // [R4]
        end else begin
            st_nxt.mwarn_f = 1'b0;
            st_nxt.merr = (st_r.merr & ~err_clr) | st_r.hot_s; // [R3]
        end
        st_nxt.drv_off = st_r.err30 | st_r.err31 | st_r.hs_shut | st_r.merr;
        st_nxt.ecode = st_r.err30 ? ERR_I2T : (st_r.err31 ? ERR_OVL : ERR_NONE);
        // Setpoint generator
        if (sp_wrap) begin
            st_nxt.tcnt = '0;
            st_nxt.tick = 1'b1; // [R17]
            if (!sp_run) begin
                st_nxt.vel = 20'sh00000;
                st_nxt.seg = 3'h0;
            end else begin
                st_nxt.pos = st_r.pos + {{12{st_r.vel[19]}}, st_r.vel};
                if (sp_diff == 21'sh000000) begin
                    st_nxt.seg = 3'h0;
                end else begin
                    st_nxt.seg = st_r.seg + 3'h1;
                    if ((sp_diff <= sp_a) && (sp_diff >= -sp_a)) begin
                        st_nxt.vel = sp_vel_tgt;
                    end else if (sp_diff > 0) begin
                        st_nxt.vel = 20'({st_r.vel[19], st_r.vel} + sp_a); // [R16]
                    end else begin
                        st_nxt.vel = 20'({st_r.vel[19], st_r.vel} - sp_a); // [R16]
                    end
                end
            end
        end else begin
            st_nxt.tcnt = st_r.tcnt + SP_CNT_W'(1);
        end
        // Position sensing
        if (res_vld) begin
            st_nxt.ang = res_raw[15:16-RES_ANG_W]; // [R18]
        end
        if (sc_vld) begin
            st_nxt.scp = sc_pos_raw[15:16-SC_POS_W]; // [R19]
            st_nxt.scv = sc_vel_raw[23:24-SC_VEL_W]; // [R19]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0; // [R8]
            st_r.nom <= NOM_MA_RST; // [R7]
            st_r.fac <= OVL_FAC_RST;
            st_r.tc <= TC_S_RST;
            st_r.k <= {8'h00, K_RST};
            st_r.wpct <= WARN_PCT_RST;
            st_r.mwarn <= MOT_WARN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    assign i2t_pct   = st_r.pct;
    assign i2t_warn  = st_r.i2t_warn;
    assign i2t_err   = st_r.err30;
    assign ovl_err   = st_r.err31;
    assign err_code  = st_r.ecode;
    assign hs_alarm  = st_r.hs_alarm;
    assign hs_shut   = st_r.hs_shut;
    assign mot_deg   = st_r.mdeg;
    assign mot_warn  = st_r.mwarn_f;
    assign mot_err   = st_r.merr;
    assign drive_off = st_r.drv_off;
    assign sp_tick   = st_r.tick;
    assign sp_pos    = st_r.pos;
    assign sp_vel    = st_r.vel;
    assign res_ang   = st_r.ang;
    assign sc_pos    = st_r.scp;
    assign sc_vel    = st_r.scv;
    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    AST_HS_SHUT: assert property (hs_vld && (hs_temp >= HS_SHUT_C) |=> hs_shut ##1 drive_off) // [R1]
        else $error("heat-sink shutdown missed");
    AST_HS_ALARM: assert property (hs_vld |=> (hs_alarm == ($past(hs_temp) >= HS_ALARM_C))) // [R2]
        else $error("heat-sink alarm wrong");
    AST_MOT_SW: assert property (!lin && st_r.hot_s && !$past(cfg_wr) |=> mot_err) // [R3]
        else $error("motor sensor error missed");
    AST_MOT_LIN: assert property (lin && mot_vld && !cfg_wr |=> (mot_deg == $past(deg_c)) && // [R4]
        (mot_err || $past(deg_c) < MOT_MAX_C))
        else $error("linear sensor reading wrong");
    AST_I2T_ERR: assert property (st_r.en && hit30 |=> i2t_err ##1 (err_code == ERR_I2T)) // [R6]
        else $error("model error 30 missed");
    AST_I2T_OFF: assert property ($rose(i2t_err) |-> $past(st_r.en)) // [R6]
        else $error("error 30 while model off");
    AST_RST_DEF: assert property (!st_r.cfg_seen |-> (st_r.nom == NOM_MA_RST) && (st_r.fac == OVL_FAC_RST) && // [R7]
        (st_r.tc == TC_S_RST))
        else $error("reset defaults lost");
    AST_ACC_ZERO: assert property (!st_r.en |=> (st_r.acc_i2t == 56'h0) && (i2t_pct == 16'h0000)) // [R8]
        else $error("model not held at zero");
    AST_PCT: assert property (st_r.job == JOB_PCT && dv.done && st_r.en && !cfg_wr |=> // [R9]
        (i2t_pct == (($past(dv.quo) > 40'hFFFF) ? 16'hFFFF : $past(dv.quo[15:0]))))
        else $error("percentage not updated");
    AST_OVL_TRIP: assert property (hit31 |=> ovl_err ##1 drive_off) // [R14]
        else $error("fixed trip missed");
    AST_SP_TICK: assert property (sp_tick |-> ($past(st_r.tcnt) == SP_CNT_W'(SP_CYCLES - 1)) && (st_r.tcnt == 0)) // [R17]
        else $error("setpoint period wrong");
    AST_RES: assert property (res_vld |=> (res_ang == $past(res_raw[15:4]))) // [R18]
        else $error("resolver angle wrong");
    COV_ERR30: cover property (st_r.en ##1 $rose(i2t_err));
    COV_ERR31: cover property ($rose(ovl_err));
    COV_SHUT: cover property ($rose(hs_alarm) ##[1:100] $rose(hs_shut));
    COV_SIN2: cover property (sp_tick && st_r.asin && st_r.seg == 3'h7);
endmodule : mop_top
`default_nettype wire

// file: testbench/mop_plant.sv
// Current measurement model feeding the amps value as each sample
`timescale 1ns/1ns
`default_nettype none
module mop_plant (
    input  wire logic        core_clk,
    input  wire logic        run,
    input  wire logic [15:0] amps,
    output logic             cur_vld,
    output logic [15:0]      cur_ma
);
    // One sample per cycle while running; idle bus shows the inverse
    always @(negedge core_clk) begin
        cur_vld <= run;
        cur_ma  <= run ? amps : ~amps;
    end
endmodule : mop_plant
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench of the motor overload protection block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import mop_pkg::*;
    logic core_clk = 1'h0, rstn = 1'h0, cfg_wr = 1'h0, cfg_i2t_en = 1'h0, err_clr = 1'h0, run = 1'h0;
    logic cfg_acc_sin2 = 1'h0, cfg_dec_sin2 = 1'h0, sp_run = 1'h0, hs_vld = 1'h0, mot_hot = 1'h0;
    logic mot_vld = 1'h0, res_vld = 1'h0, sc_vld = 1'h0;
    logic [15:0] cfg_nom_ma = 16'h0, cfg_tc_s = 16'h0, sp_acc = 16'h0, amps = 16'h0;
    logic [15:0] res_raw = 16'h0, sc_pos_raw = 16'h0, cur_ma, i2t_pct;
    logic [9:0] cfg_mot_warn_c = 10'h0;
    logic [7:0] cfg_warn_pct = WARN_PCT_RST, err_code;
    logic [3:0] cfg_ovl_fac = 4'h0;
    logic [1:0] cfg_sens_type = 2'h0;
    logic [11:0] mot_raw = 12'h0, res_ang;
    logic [23:0] sc_vel_raw = 24'h0;
    logic signed [19:0] sp_vel_tgt = 20'sh0, sp_vel;
    logic signed [9:0] hs_temp = 10'sh0, mot_deg;
    logic cur_vld, i2t_warn, i2t_err, ovl_err, hs_alarm, hs_shut, mot_warn, mot_err, drive_off, sp_tick;
    logic signed [31:0] sp_pos;
    logic [14:0] sc_pos;
    logic [19:0] sc_vel;
    int err_count = 0, checks_done = 0, n;
    mop_top #(.SP_CYCLES(50)) dut_u (.*);
    mop_plant plant_u (.*);
    always #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic cyc(input int k);
        repeat (k) @(negedge core_clk);
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'h1;
        cyc(1);
        s = 1'h0;
        cyc(3);
    endtask : pulse
    task automatic cfg(input logic [15:0] nom, tc, input logic [3:0] fac, input logic en, input logic [1:0] st);
        {cfg_nom_ma, cfg_tc_s, cfg_ovl_fac, cfg_i2t_en, cfg_sens_type} = {nom, tc, fac, en, st};
        pulse(cfg_wr);
        cyc(100);
    endtask : cfg
    task automatic hs(input logic signed [9:0] t);
        hs_temp = t;
        pulse(hs_vld);
    endtask : hs
    ////////////////////////////////////////////////////////////////
    task automatic t_sense();
        {res_raw, sc_pos_raw, sc_vel_raw} = {16'hABCD, 16'hABCD, 24'h123456};
        {res_vld, sc_vld} = 2'h3;
        cyc(1);
        {res_vld, sc_vld} = 2'h0;
        cyc(2);
        chk(res_ang, 12'hABC);
        chk(sc_pos, 15'h55E6);
        chk(sc_vel, 20'h12345);
    endtask : t_sense
    task automatic wait_tick();
        for (n = 1; n < 200 && sp_tick !== 1'h1; n++) cyc(1);
        if (n == 200) begin
            err_count++;
            finish_test();
        end
    endtask : wait_tick
    task automatic t_tick();
        wait_tick();
        cyc(1);
        wait_tick();
        chk(n, 32'h32);
    endtask : t_tick
    task automatic t_heat();
        hs(10'sh04F);
        chk(hs_alarm, 1'h0);
        hs(10'sh050);
        chk({hs_alarm, hs_shut}, 2'h2);
        hs(10'sh054);
        chk(hs_shut, 1'h0);
        hs(10'sh055);
        chk({hs_shut, drive_off}, 2'h3);
        hs(10'sh028);
        pulse(err_clr);
        chk({hs_alarm, hs_shut}, 2'h0);
    endtask : t_heat
    task automatic t_mot();
        cfg_mot_warn_c = 10'h064;
        cfg(16'h0BB8, 16'h0708, 4'h2, 1'h0, SENS_SWITCH);
        mot_hot = 1'h1;
        cyc(8);
        chk(mot_err, 1'h1);
        mot_hot = 1'h0;
        cyc(8);
        pulse(err_clr);
        cfg(16'h0BB8, 16'h0708, 4'h2, 1'h0, SENS_LIN_A);
        mot_raw = 12'h690;
        pulse(mot_vld);
        chk({mot_deg, mot_warn, mot_err}, {10'h06E, 2'h2});
        mot_raw = 12'h320;
        pulse(mot_vld);
        chk({mot_deg, mot_warn}, {10'h000, 1'h0});
    endtask : t_mot
    task automatic t_i2t();
        cfg(16'h03E8, 16'h0001, 4'h4, 1'h1, SENS_SWITCH);
        amps = 16'h0BB8;
        run = 1'h1;
        cyc(1000);
        chk({i2t_err, i2t_warn, i2t_pct != 16'h0}, 3'h1);
        for (n = 0; n < 4000 && i2t_err !== 1'h1; n++) cyc(1);
        if (n == 4000) begin
            err_count++;
            finish_test();
        end
        cyc(3);
        chk({i2t_err, err_code, ovl_err, drive_off}, {1'h1, ERR_I2T, 2'h1});
        run = 1'h0;
        cfg(16'h03E8, 16'h0001, 4'h4, 1'h0, SENS_SWITCH);
        chk(i2t_pct, 16'h0);
    endtask : t_i2t
    task automatic t_ramp();
        cfg_acc_sin2 = 1'h1;
        pulse(cfg_wr);
        {sp_acc, sp_vel_tgt, sp_run} = {16'h0040, 20'sh01000, 1'h1};
        repeat (3) begin
            cyc(1);
            wait_tick();
        end
        sp_vel_tgt = 20'sh00000;
        cyc(1);
        wait_tick();
        chk(sp_vel, 32'h45);
        chk(sp_pos, 32'hB7);
    endtask : t_ramp
    ////////////////////////////////////////////////////////////////
    initial begin
        cyc(20);
        rstn = 1'h1;
        cyc(2);
        chk({i2t_pct, err_code, drive_off}, 25'h0);
        t_sense();
        t_tick();
        t_heat();
        t_mot();
        t_i2t();
        t_ramp();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
